// ---- serial_transmitter_async_sync.sv ----
// transmit half of the serial port: asynchronous frames and synchronous master
`timescale 1ns/10ps

// Function
// - clocked-mode select clear means asynchronous mode
// - frame: start, eight or nine data, stop
// - least significant bit first, shared format
// - divisor is low byte or high:low
// - sixteen or sixty-four ticks per bit
// - no parity; ninth bit sent as given
// - asynchronous reload only after stop bit sent
// - flag set always, cleared only by write
// - cleared flag visible second instruction cycle
// - interrupt request gated by its enable
// - shift-empty status while shift register empty
// - setting transmit enable sets the flag
// - ninth bit sent last when enabled
// - clock source and clocked mode: master
// - synchronous mode half duplex, transmit waits for reception
// - master drives the shift clock line
// - polarity select sets clock idle level
// - synchronous reload right after last bit
module serial_transmitter_async_sync (
	input  wire logic                          clk,
	input  wire logic                          rstn,
	input  wire logic                          ce,
	input  wire serial_tx_pkg::serial_cfg_s    cfg,
	input  wire logic                          holding_write,
	input  wire logic [7:0]                    holding_data,
	input  wire logic                          receive_active,
	output serial_tx_pkg::serial_status_s      status,
	output logic                               transmit_pin_out,
	output logic                               transmit_pin_oe,
	output logic                               data_pin_out,
	output logic                               data_pin_oe
);
	import serial_tx_pkg::*;

	// ==========================================================
	// declarations
	tx_state_e   state;
	logic [1:0]  instr_cnt;
	logic        instr_tick;
	logic [15:0] baud_cnt;
	logic        baud_tick;
	logic [6:0]  ovs_cnt;
	logic        bit_end;
	logic        first_half;
	logic [3:0]  bit_idx;
	logic        last_bit;
	logic [8:0]  shift;
	logic [7:0]  holding;
	logic        holding_ninth;
	logic        holding_full;
	logic        empty_flag;
	logic [1:0]  clear_wait;
	logic        enable_prev;
	logic        enable_rise;
	logic        load_done;
	logic        sync_mode;
	logic        run;
	logic        can_start;
	logic        shift_empty;
	logic        pin_a;
	logic        pin_b;

	// ==========================================================
	// helpers
	function automatic logic [15:0] divisor(input serial_cfg_s c);
		divisor = c.wide_divider_select ? {c.baud_divisor_high, c.baud_divisor_low}
			: {8'h00, c.baud_divisor_low};
	endfunction : divisor

	// high-speed select is ignored in synchronous mode
	function automatic logic [6:0] oversample(input serial_cfg_s c, input logic sync);
		oversample = (sync || c.high_speed_select || c.wide_divider_select)
			? OVS_FAST : OVS_SLOW;
	endfunction : oversample

	// ==========================================================
	// mode decode
	assign sync_mode = cfg.clocked_mode_select;
	// clocked mode without clock source is slave mode, which is not built
	assign run = cfg.serial_port_enable && cfg.transmit_enable_bit
		&& (!sync_mode || cfg.clock_source_select);
	assign can_start = run && holding_full && !(sync_mode && receive_active);
	assign last_bit = (bit_idx == (cfg.nine_bit_transmit_enable ? LAST_BIT_NINE
		: LAST_BIT_EIGHT));
	assign first_half = (ovs_cnt < (oversample(cfg, sync_mode) >> 1));
	assign bit_end = baud_tick && (ovs_cnt == 7'(oversample(cfg, sync_mode) - 7'h01));
	assign enable_rise = cfg.transmit_enable_bit && !enable_prev;

	// ==========================================================
	// instruction cycle
	assign instr_tick = (instr_cnt == INSTR_LAST);

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			instr_cnt <= 2'h0;
		else if (ce)
			instr_cnt <= instr_tick ? 2'h0 : 2'(instr_cnt + 2'h1);
	end

	// ==========================================================
	// baud generator, restarted at each load so the first bit is full length
	assign baud_tick = (baud_cnt == 16'h0000);

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			baud_cnt <= DIVISOR_RESET;
		else if (ce)
		begin
			if (state == ST_IDLE || state == ST_LOAD || baud_tick)
				baud_cnt <= divisor(cfg);
			else
				baud_cnt <= 16'(baud_cnt - 16'h0001);
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			ovs_cnt <= 7'h00;
		else if (ce)
		begin
			if (state == ST_IDLE || state == ST_LOAD || bit_end)
				ovs_cnt <= 7'h00;
			else if (baud_tick)
				ovs_cnt <= 7'(ovs_cnt + 7'h01);
		end
	end

	// ==========================================================
	// holding register; a write while full overwrites the waiting word
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			holding       <= 8'h00;
			holding_ninth <= 1'b0;
		end
		else if (ce && holding_write)
		begin
			holding       <= holding_data;
			holding_ninth <= cfg.ninth_transmit_bit;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			holding_full <= 1'b0;
		else if (ce)
		begin
			if (holding_write)
				holding_full <= 1'b1;
			else if (load_done)
				holding_full <= 1'b0;
		end
	end

	// ==========================================================
	// transmit-empty flag; software has no direct clear
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			enable_prev <= 1'b0;
		else if (ce)
			enable_prev <= cfg.transmit_enable_bit;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			clear_wait <= 2'h0;
		else if (ce)
		begin
			if (holding_write)
				clear_wait <= CLEAR_DELAY;
			else if (instr_tick && clear_wait != 2'h0)
				clear_wait <= 2'(clear_wait - 2'h1);
		end
	end

	// set wins over the delayed clear
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			empty_flag <= 1'b0;
		else if (ce)
		begin
			if (load_done || enable_rise)
				empty_flag <= 1'b1;
			else if (instr_tick && clear_wait == 2'h1 && holding_full)
				empty_flag <= 1'b0;
		end
	end

	// ==========================================================
	// transmit sequencer
	always_comb
	begin
		load_done = 1'b0;
		if (run && state == ST_LOAD && instr_tick)
			load_done = 1'b1;
		else if (run && state == ST_DATA && bit_end && last_bit && sync_mode && can_start)
			load_done = 1'b1;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			state <= ST_IDLE;
		else if (ce)
		begin
			if (!run)
				state <= ST_IDLE;
			else
			begin
				unique case (state)
					ST_IDLE:
						if (can_start)
							state <= ST_LOAD;
					ST_LOAD:
						if (instr_tick)
							state <= sync_mode ? ST_DATA : ST_START;
					ST_START:
						if (bit_end)
							state <= ST_DATA;
					ST_DATA:
						if (bit_end && last_bit)
						begin
							if (!sync_mode)
								state <= ST_STOP;
							else if (!can_start)
								state <= ST_IDLE;
						end
					ST_STOP:
						if (bit_end)
							state <= can_start ? ST_LOAD : ST_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			bit_idx <= 4'h0;
		else if (ce)
		begin
			if (load_done)
				bit_idx <= 4'h0;
			else if (state == ST_DATA && bit_end)
				bit_idx <= 4'(bit_idx + 4'h1);
		end
	end

	// no parity is formed; the ninth bit goes out exactly as written
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			shift <= SHIFT_RESET;
		else if (ce)
		begin
			if (load_done)
				shift <= {holding_ninth, holding};
			else if (state == ST_DATA && bit_end)
				shift <= {1'b0, shift[8:1]};
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			shift_empty <= 1'b1;
		else if (ce)
			shift_empty <= !run || (state == ST_IDLE) || (state == ST_LOAD && !instr_tick)
				|| (state == ST_STOP && bit_end);
	end

	// ==========================================================
	// pins; the transmit pin carries async data or the master clock
	always_comb
	begin
		pin_a = 1'b1;
		// data holds after a word so it never moves with the clock at idle
		pin_b = data_pin_out;
		if (sync_mode)
		begin
			pin_a = cfg.clock_polarity_select;
			if (state == ST_DATA)
			begin
				pin_a = first_half ? !cfg.clock_polarity_select
					: cfg.clock_polarity_select;
				pin_b = shift[0];
			end
		end
		else
		begin
			unique case (state)
				ST_START: pin_a = 1'b0;
				ST_DATA:  pin_a = shift[0];
				default:  pin_a = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			transmit_pin_out <= 1'b1;
			transmit_pin_oe  <= 1'b0;
			data_pin_out     <= 1'b0;
			data_pin_oe      <= 1'b0;
		end
		else if (ce)
		begin
			transmit_pin_out <= pin_a;
			transmit_pin_oe  <= cfg.serial_port_enable
				&& (!sync_mode || cfg.clock_source_select);
			data_pin_out     <= pin_b;
			data_pin_oe      <= run && sync_mode;
		end
	end

	// ==========================================================
	// status
	assign status.transmit_empty_flag = empty_flag;
	assign status.transmit_irq        = empty_flag && cfg.transmit_interrupt_enable;
	assign status.shift_empty_status  = shift_empty;
	assign status.transmit_active     = sync_mode && !shift_empty;

endmodule : serial_transmitter_async_sync

// ---- serial_tx_pkg.sv ----
// constants and carrier types for the serial transmitter
package serial_tx_pkg;

	// ==========================================================
	// timing
	localparam int          CLOCK_MHZ        = 250;
	localparam int          INSTR_CYCLE_NS   = 16;
	localparam int          INSTR_CLKS       = (INSTR_CYCLE_NS * CLOCK_MHZ) / 1000;
	localparam logic [1:0]  INSTR_LAST       = 2'(INSTR_CLKS - 1);
	localparam logic [1:0]  CLEAR_DELAY      = 2'h2;

	// ==========================================================
	// oversampling and frame
	localparam logic [6:0]  OVS_SLOW         = 7'h40;
	localparam logic [6:0]  OVS_FAST         = 7'h10;
	localparam logic [3:0]  LAST_BIT_EIGHT   = 4'h7;
	localparam logic [3:0]  LAST_BIT_NINE    = 4'h8;
	localparam logic [8:0]  SHIFT_RESET      = 9'h000;
	localparam logic [15:0] DIVISOR_RESET    = 16'h0000;

	// ==========================================================
	// carrier types
	typedef struct packed {
		logic       serial_port_enable;
		logic       clocked_mode_select;
		logic       clock_source_select;
		logic       transmit_enable_bit;
		logic       nine_bit_transmit_enable;
		logic       ninth_transmit_bit;
		logic       high_speed_select;
		logic       wide_divider_select;
		logic       clock_polarity_select;
		logic       transmit_interrupt_enable;
		logic [7:0] baud_divisor_high;
		logic [7:0] baud_divisor_low;
	} serial_cfg_s;

	typedef struct packed {
		logic transmit_empty_flag;
		logic transmit_irq;
		logic shift_empty_status;
		logic transmit_active;
	} serial_status_s;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LOAD,
		ST_START,
		ST_DATA,
		ST_STOP
	} tx_state_e;

endpackage : serial_tx_pkg

// ---- serial_tx_checker.sv ----
// port assertions for the serial transmitter
`timescale 1ns/10ps
// ==========================================
// checker
module serial_tx_checker
	import serial_tx_pkg::*;
(
	input wire logic           clk,
	input wire logic           rstn,
	input wire serial_cfg_s    cfg,
	input wire logic           holding_write,
	input wire logic           receive_active,
	input wire serial_status_s status,
	input wire logic           transmit_pin_out,
	input wire logic           data_pin_out,
	input wire logic           data_pin_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [3:0] since_wr;
	wire        en = cfg.serial_port_enable & cfg.transmit_enable_bit;
	wire        arun = en & !cfg.clocked_mode_select;
	wire        srun = en & cfg.clocked_mode_select & cfg.clock_source_select;
	wire        empty = status.shift_empty_status;
	// saturates so an old write never looks recent
	always_ff @(posedge clk or negedge rstn)
		if (!rstn) since_wr <= 4'hF;
		else if (holding_write) since_wr <= 4'h0;
		else if (since_wr != 4'hF) since_wr <= since_wr + 4'h1;
	sequence two_empty; empty ##1 empty; endsequence
	a_irq_gated: assert property (status.transmit_irq == (status.transmit_empty_flag & cfg.transmit_interrupt_enable))
		else $error("irq not flag and enable");
	a_enable_sets: assert property ($rose(cfg.transmit_enable_bit) |=> status.transmit_empty_flag)
		else $error("enable did not set flag");
	a_flag_clear_time: assert property ($fell(status.transmit_empty_flag) |-> since_wr inside {[4'h2:4'hA]})
		else $error("flag cleared without recent write");
	a_load_soon: assert property (arun && holding_write && empty |-> ##[1:7] !empty)
		else $error("no load after write");
	a_start_low: assert property (arun && $fell(empty) |-> ##[0:2] !transmit_pin_out)
		else $error("no start bit");
	a_idle_high: assert property (arun ##0 two_empty |-> transmit_pin_out)
		else $error("async line not idle high");
	a_clk_idle: assert property (srun && $past(srun) ##0 two_empty |-> transmit_pin_out == cfg.clock_polarity_select)
		else $error("clock idle level wrong");
	a_half_duplex: assert property (srun && receive_active && empty |=> empty)
		else $error("sent while receiving");
	a_data_edge: assert property (srun && data_pin_oe && $past(data_pin_oe) && $changed(data_pin_out) |-> transmit_pin_out != cfg.clock_polarity_select)
		else $error("data moved on wrong edge");
endmodule : serial_tx_checker

bind serial_transmitter_async_sync serial_tx_checker u_serial_tx_checker (.clk(clk), .rstn(rstn), .cfg(cfg), .holding_write(holding_write), .receive_active(receive_active), .status(status), .transmit_pin_out(transmit_pin_out), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe));

// ---- serial_far_end.sv ----
// far-end model: async receiver and sync slave
`timescale 1ns/10ps
// ==========================================
// model
module serial_far_end (
	input wire logic        clk,
	input wire logic        sync_mode,
	input wire logic        polarity,
	input wire logic        nine,
	input wire logic [7:0]  bit_clks,
	input wire logic        line_a,
	input wire logic        line_d,
	output logic [8:0]      last_word,
	output logic [7:0]      words,
	output logic [7:0]      frame_errs
);
	logic [8:0] acc;
	logic [3:0] n;
	logic       prev_a;
	int         i;
	initial begin words = 0; frame_errs = 0; last_word = 0; n = 0; acc = 0; prev_a = 1; end
	// async: sample mid-bit, lsb first, stop must be high
	always begin
		@(negedge line_a);
		if (!sync_mode)
		begin
			repeat (bit_clks / 2) @(posedge clk);
			if (line_a) frame_errs++;
			acc = 0;
			for (i = 0; i < (nine ? 9 : 8); i++)
			begin
				repeat (bit_clks) @(posedge clk);
				acc[i] = line_a;
			end
			repeat (bit_clks) @(posedge clk);
			if (!line_a) frame_errs++;
			last_word = acc;
			words++;
		end
	end
	// sync slave: take data where the clock returns to idle
	always @(posedge clk)
	begin
		if (!sync_mode) n = 0;
		else if (prev_a == !polarity && line_a == polarity)
		begin
			acc[n] = line_d;
			n++;
			if (n == 4'h8) begin last_word = {1'b0, acc[7:0]}; words++; n = 0; end
		end
		prev_a = line_a;
	end
endmodule : serial_far_end

// ---- test_serial_transmitter_async_sync.sv ----
// self-checking bench for the serial transmitter
`timescale 1ns/10ps
// ==========================================
// bench
module test_serial_transmitter_async_sync;
	import serial_tx_pkg::*;
	logic           clk, rstn, ce, holding_write, receive_active;
	logic [7:0]     holding_data, words, frame_errs, bit_clks;
	logic [8:0]     last_word;
	serial_cfg_s    cfg;
	serial_status_s status;
	logic           tx_out, tx_oe, d_out, d_oe;
	int             bad_count, checks_done, cycles;
	initial begin clk = 0; forever #2 clk = ~clk; end
	serial_transmitter_async_sync u_serial_transmitter_async_sync (.clk(clk), .rstn(rstn), .ce(ce), .cfg(cfg), .holding_write(holding_write), .holding_data(holding_data), .receive_active(receive_active), .status(status), .transmit_pin_out(tx_out), .transmit_pin_oe(tx_oe), .data_pin_out(d_out), .data_pin_oe(d_oe));
	// released lines read as the pull-up level
	serial_far_end u_serial_far_end (.clk(clk), .sync_mode(cfg.clocked_mode_select), .polarity(cfg.clock_polarity_select), .nine(cfg.nine_bit_transmit_enable), .bit_clks(bit_clks), .line_a(tx_oe ? tx_out : 1'b1), .line_d(d_oe ? d_out : 1'b1), .last_word(last_word), .words(words), .frame_errs(frame_errs));
	task chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		checks_done++;
		if (got !== exp) begin bad_count++; $display("BAD %s expected %h seen %h", what, exp, got); end
	endtask : chk
	task put(input logic [7:0] d);
		@(negedge clk) holding_write = 1; holding_data = d;
		@(negedge clk) holding_write = 0;
	endtask : put
	task got(input logic [7:0] n, input logic [8:0] exp);
		for (int k = 0; k < 3000 && words < n; k++) @(negedge clk);
		chk("count", {1'b0, n}, {1'b0, words});
		chk("word", exp, last_word);
	endtask : got
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : test_done
	always @(posedge clk) begin cycles++; if (cycles == 20000) begin bad_count++; test_done(); end end
	task t_async;
		cfg.high_speed_select = 1; bit_clks = 8'h10;
		@(negedge clk) cfg.serial_port_enable = 1;
		@(negedge clk) cfg.transmit_enable_bit = 1;
		repeat (2) @(negedge clk);
		chk("flag", 1, status.transmit_empty_flag);
		chk("irq", 0, status.transmit_irq);
		cfg.transmit_interrupt_enable = 1;
		#1 chk("irq", 1, status.transmit_irq);
		put(8'hA5);
		repeat (8) @(negedge clk);
		put(8'h3C);
		chk("flag", 1, status.transmit_empty_flag);
		repeat (12) @(negedge clk);
		chk("flag", 0, status.transmit_empty_flag);
		chk("empty", 0, status.shift_empty_status);
		got(1, 9'h0A5);
		got(2, 9'h03C);
		repeat (40) @(negedge clk);
		chk("empty", 1, status.shift_empty_status);
		chk("flag", 1, status.transmit_empty_flag);
	endtask : t_async
	task t_nine;
		cfg.wide_divider_select = 1; cfg.high_speed_select = 0; cfg.baud_divisor_low = 8'h01;
		cfg.nine_bit_transmit_enable = 1; cfg.ninth_transmit_bit = 1; bit_clks = 8'h20;
		put(8'h55);
		got(3, 9'h155);
		cfg.ninth_transmit_bit = 0;
		put(8'hFF);
		got(4, 9'h0FF);
		chk("frame", 0, frame_errs);
	endtask : t_nine
	task t_sync;
		cfg.nine_bit_transmit_enable = 0; cfg.baud_divisor_low = 8'h00; cfg.high_speed_select = 1;
		cfg.clock_polarity_select = 1; cfg.clock_source_select = 1; cfg.clocked_mode_select = 1;
		receive_active = 1;
		put(8'h96);
		repeat (20) @(negedge clk);
		chk("empty", 1, status.shift_empty_status);
		receive_active = 0;
		repeat (8) @(negedge clk);
		put(8'h4B);
		chk("active", 1, status.transmit_active);
		chk("data oe", 1, d_oe);
		chk("clock oe", 1, tx_oe);
		got(5, 9'h096);
		got(6, 9'h04B);
		chk("clk idle", 1, tx_out);
	endtask : t_sync
	initial
	begin
		rstn = 0; ce = 1; cfg = '0; holding_write = 0; holding_data = 8'h00; receive_active = 0;
		bit_clks = 8'h10; bad_count = 0; checks_done = 0; cycles = 0;
		repeat (12) @(negedge clk);
		chk("flag", 0, status.transmit_empty_flag);
		chk("empty", 1, status.shift_empty_status);
		chk("pin oe", 0, tx_oe);
		chk("data oe", 0, d_oe);
		rstn = 1;
		t_async();
		t_nine();
		t_sync();
		test_done();
	end
endmodule : test_serial_transmitter_async_sync
